// [src/mci_pkg.sv]
// Package for the monitor configuration and fault-interrupt control block.
// Assumes one system clock and a synchronous active-low reset.
package mci_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_MONITOR_CONFIGURATION = 8'h40;
    localparam logic [7:0] OFF_FAULT_FLAGS_PRIMARY   = 8'h41;
    localparam logic [7:0] OFF_FAULT_FLAGS_SECONDARY = 8'h42;
    localparam logic [7:0] OFF_FAULT_MASK_PRIMARY    = 8'h43;
    localparam logic [7:0] OFF_FAULT_MASK_SECONDARY  = 8'h44;
    localparam logic [7:0] OFF_INTRUSION_CLEAR       = 8'h46;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_MONITOR_CONFIGURATION = 8'h08;
    localparam logic [7:0] RST_FAULT_FLAGS           = 8'h00;
    localparam logic [7:0] RST_FAULT_MASK            = 8'h00;
    localparam logic [7:0] RST_INTRUSION_CLEAR       = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_START_BIT     = 0;
    localparam int CFG_IRQ_EN_BIT    = 1;
    localparam int CFG_IRQ_CLR_BIT   = 3;
    localparam int CFG_RST_PULSE_BIT = 4;
    localparam int CFG_INTR_PULSE_BIT = 6;
    localparam int CFG_REINIT_BIT    = 7;
    localparam int MASK2_RST_EN_BIT  = 7;
    localparam int ICLR_PULSE_BIT    = 7;
    localparam logic [7:0] FLAGS1_USED = 8'hDF;
    localparam logic [7:0] FLAGS2_USED = 8'h13;
    localparam logic [7:0] CFG_WR_MASK = 8'hDB;
    localparam int FLAGS2_INTR_BIT   = 4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ         = 250;
    localparam int PULSE_MIN_MS    = 20;
    localparam int PULSE_CYCLES    = PULSE_MIN_MS * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {
        PULSE_IDLE,
        PULSE_ACTIVE
    } mci_pulse_state_t;
endpackage : mci_pkg

// [src/mci_pulse_gen.sv]
// Minimum-width active-high pulse generator.
// Assumes start is a one-cycle request from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module mci_pulse_gen #(
    parameter int WIDTH_CYCLES = mci_pkg::PULSE_CYCLES
) (
    input  wire logic MCLK_I,
    input  wire logic RST_N_I,
    input  wire logic start_i,
    output var  logic active_o,
    output var  logic done_o
);
    import mci_pkg::*;

    mci_pulse_state_t state_ff;
    logic [31:0]      cnt_ff;

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            state_ff <= PULSE_IDLE;
            cnt_ff   <= 32'h0;
            active_o <= 1'b0;
            done_o   <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state_ff)
                PULSE_IDLE: begin
                    if (start_i) begin
                        state_ff <= PULSE_ACTIVE;
                        cnt_ff   <= 32'(WIDTH_CYCLES - 1);
                        active_o <= 1'b1;
                    end
                end
                PULSE_ACTIVE: begin
                    if (cnt_ff == 32'h0) begin
                        state_ff <= PULSE_IDLE;
                        active_o <= 1'b0;
                        done_o   <= 1'b1;
                    end else begin
                        cnt_ff <= cnt_ff - 32'h1;
                    end
                end
                default: begin
                    state_ff <= PULSE_IDLE;
                    active_o <= 1'b0;
                end
            endcase
        end
    end

    // Pulse stays high for at least 8 cycles once started
    AST_PULSE_WIDTH: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) $rose(active_o) |-> active_o [*8])
        else $error("pulse shorter than minimum");
    COV_PULSE_DONE: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
        done_o);
endmodule : mci_pulse_gen
`default_nettype wire

// [src/mci_sync2.sv]
// Two-stage synchroniser for pin inputs.
// Assumes the inputs are asynchronous to MCLK_I.
`timescale 1ns/1ps
`default_nettype none
module mci_sync2 #(
    parameter int W = 1
) (
    input  wire logic         MCLK_I,
    input  wire logic         RST_N_I,
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            meta_ff <= '0;
            q_o     <= '0;
        end else begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule : mci_sync2
`default_nettype wire

// [src/mci_top.sv]
// Configuration and fault-interrupt control of a system hardware monitor.
// Assumes a serial bus front end giving one-cycle register strobes,
// and the monitor core giving fault pulses and a temperature event.
//
// Overview of operation
// - Config bit 0 starts monitoring; zero means standby; resets to zero.
// - Clearing the start bit never releases the interrupt output.
// - Config bit 1 enables the active-low interrupt output; resets disabled.
// - Config bit 3 releases interrupt, keeps status; resets to one.
// - Monitoring is suspended while config bit 3 is set.
// - Config bit 4 fires 20 ms reset pulse, clears when pulse active.
// - Reset pulse works only while second mask bit 7 is one.
// - Config bit 6 fires 20 ms intrusion pin pulse, like clear register.
// - Config bit 7 restores defaults of config, flags, masks; reads zero.
// - Primary flags bits 0 to 3 record supply rail limit faults.
// - Primary flags bits 6 and 7 record fan one and two faults.
// - Primary flag bit 4 records temperature event; bit 5 reserved.
// - Secondary flags: 12 V bit 0, core two bit 1, intrusion bit 4.
// - Reading a flags register clears what it returned; reset zero.
// - While monitoring runs, persisting faults other than intrusion set their flag again after a clearing read.
// - Mask bit one blocks matching flag from the interrupt; masks reset zero.
// - Intrusion clear bit clears itself after its pulse has finished.
`timescale 1ns/1ps
`default_nettype none
module mci_top #(
    parameter int PULSE_CYCLES_P = mci_pkg::PULSE_CYCLES
) (
    input  wire logic       MCLK_I,
    input  wire logic       RST_N_I,
    input  wire logic       REG_WR_I,
    input  wire logic       REG_RD_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    output var  logic [7:0] REG_RDATA_O,
    input  wire logic [7:0] FAULT_PRIMARY_I,
    input  wire logic [7:0] FAULT_SECONDARY_I,
    input  wire logic       INTRUSION_PIN_I,
    output var  logic       INTRUSION_PIN_OE_O,
    output var  logic       INTRUSION_PIN_O,
    output var  logic       RESET_OUT_N_O,
    output var  logic       IRQ_N_O,
    output var  logic       MONITOR_RUN_O,
    output var  logic       REINIT_O
);
    import mci_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] cfg_ff;
    logic [7:0] flags1_ff;
    logic [7:0] flags2_ff;
    logic [7:0] mask1_ff;
    logic [7:0] mask2_ff;
    logic       iclr_ff;
    logic       intr_sync;
    logic       intr_prev_ff;
    logic       rst_active;
    logic       rst_done;
    logic       intr_active;
    logic       intr_done;
    logic       rst_start_ff;
    logic       intr_start_ff;
    logic       wr_cfg;
    logic       reinit;
    logic       rd_f1;
    logic       rd_f2;
    logic       intr_rise;
    logic [7:0] nxt_flags1;
    logic [7:0] nxt_flags2;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction : hit

    assign wr_cfg = REG_WR_I && hit(REG_ADDR_I, OFF_MONITOR_CONFIGURATION);
    assign reinit = wr_cfg && REG_WDATA_I[CFG_REINIT_BIT];
    assign rd_f1  = REG_RD_I && hit(REG_ADDR_I, OFF_FAULT_FLAGS_PRIMARY);
    assign rd_f2  = REG_RD_I && hit(REG_ADDR_I, OFF_FAULT_FLAGS_SECONDARY);

    // ------------------------------------------------------------------
    // Intrusion pin input
    // ------------------------------------------------------------------
    mci_sync2 #(.W(1)) u_sync (
        .MCLK_I (MCLK_I),
        .RST_N_I(RST_N_I),
        .d_i    (INTRUSION_PIN_I),
        .q_o    (intr_sync)
    );

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            intr_prev_ff <= 1'b0;
        end else begin
            intr_prev_ff <= intr_sync;
        end
    end
    // Own drive of the pin is not counted as an intrusion
    assign intr_rise = intr_sync && !intr_prev_ff && !intr_active;

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            cfg_ff <= RST_MONITOR_CONFIGURATION;
        end else if (reinit) begin
            cfg_ff <= RST_MONITOR_CONFIGURATION;
        end else if (wr_cfg) begin
            // Reserved bits 2 and 5 and bit 7 never hold a one
            cfg_ff <= REG_WDATA_I & CFG_WR_MASK & 8'h7F;
        end else begin
            if (rst_active) begin
                cfg_ff[CFG_RST_PULSE_BIT] <= 1'b0;
            end
            if (intr_done) begin
                cfg_ff[CFG_INTR_PULSE_BIT] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Intrusion clear register
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            iclr_ff <= 1'b0;
        end else if (REG_WR_I && hit(REG_ADDR_I, OFF_INTRUSION_CLEAR)
                     && REG_WDATA_I[ICLR_PULSE_BIT]) begin
            iclr_ff <= 1'b1;
        end else if (intr_done) begin
            iclr_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Pulse requests
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            rst_start_ff  <= 1'b0;
            intr_start_ff <= 1'b0;
        end else begin
            rst_start_ff  <= wr_cfg && !reinit
                             && REG_WDATA_I[CFG_RST_PULSE_BIT]
                             && mask2_ff[MASK2_RST_EN_BIT];
            intr_start_ff <= !reinit && REG_WR_I
                             && ((hit(REG_ADDR_I, OFF_MONITOR_CONFIGURATION)
                                  && REG_WDATA_I[CFG_INTR_PULSE_BIT])
                                 || (hit(REG_ADDR_I, OFF_INTRUSION_CLEAR)
                                  && REG_WDATA_I[ICLR_PULSE_BIT]));
        end
    end

    mci_pulse_gen #(.WIDTH_CYCLES(PULSE_CYCLES_P)) u_rst_pulse (
        .MCLK_I  (MCLK_I),
        .RST_N_I (RST_N_I),
        .start_i (rst_start_ff),
        .active_o(rst_active),
        .done_o  (rst_done)
    );

    mci_pulse_gen #(.WIDTH_CYCLES(PULSE_CYCLES_P)) u_intr_pulse (
        .MCLK_I  (MCLK_I),
        .RST_N_I (RST_N_I),
        .start_i (intr_start_ff),
        .active_o(intr_active),
        .done_o  (intr_done)
    );

    // ------------------------------------------------------------------
    // Fault flags: set wins over a clearing read
    // ------------------------------------------------------------------
    always_comb begin
        nxt_flags1 = rd_f1 ? 8'h00 : flags1_ff;
        nxt_flags2 = rd_f2 ? 8'h00 : flags2_ff;
        if (MONITOR_RUN_O) begin
            nxt_flags1 = nxt_flags1
                         | (FAULT_PRIMARY_I & FLAGS1_USED);
            nxt_flags2 = nxt_flags2 | (FAULT_SECONDARY_I & FLAGS2_USED
                         & ~(8'h01 << FLAGS2_INTR_BIT));
        end
        if (intr_rise) begin
            nxt_flags2[FLAGS2_INTR_BIT] = 1'b1;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I || reinit) begin
            flags1_ff <= RST_FAULT_FLAGS;
            flags2_ff <= RST_FAULT_FLAGS;
        end else begin
            flags1_ff <= nxt_flags1;
            flags2_ff <= nxt_flags2;
        end
    end

    // ------------------------------------------------------------------
    // Mask registers
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I || reinit) begin
            mask1_ff <= RST_FAULT_MASK;
            mask2_ff <= RST_FAULT_MASK;
        end else if (REG_WR_I) begin
            if (hit(REG_ADDR_I, OFF_FAULT_MASK_PRIMARY)) begin
                mask1_ff <= REG_WDATA_I;
            end
            if (hit(REG_ADDR_I, OFF_FAULT_MASK_SECONDARY)) begin
                mask2_ff <= REG_WDATA_I;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            IRQ_N_O            <= 1'b1;
            MONITOR_RUN_O      <= 1'b0;
            RESET_OUT_N_O      <= 1'b1;
            INTRUSION_PIN_OE_O <= 1'b0;
            INTRUSION_PIN_O    <= 1'b0;
            REINIT_O           <= 1'b0;
        end else begin
            // Start bit takes no part here, so standby keeps the line
            IRQ_N_O <= !(cfg_ff[CFG_IRQ_EN_BIT] && !cfg_ff[CFG_IRQ_CLR_BIT]
                        && (|(flags1_ff & ~mask1_ff & FLAGS1_USED)
                         || |(flags2_ff & ~mask2_ff & FLAGS2_USED)));
            MONITOR_RUN_O <= cfg_ff[CFG_START_BIT]
                             && !cfg_ff[CFG_IRQ_CLR_BIT];
            RESET_OUT_N_O      <= !rst_active;
            INTRUSION_PIN_OE_O <= intr_active;
            INTRUSION_PIN_O    <= 1'b0;
            REINIT_O           <= reinit;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O <= 8'h00;
        end else if (REG_RD_I) begin
            case (REG_ADDR_I)
                OFF_MONITOR_CONFIGURATION: REG_RDATA_O <= cfg_ff;
                OFF_FAULT_FLAGS_PRIMARY:   REG_RDATA_O <= flags1_ff;
                OFF_FAULT_FLAGS_SECONDARY: REG_RDATA_O <= flags2_ff;
                OFF_FAULT_MASK_PRIMARY:    REG_RDATA_O <= mask1_ff;
                OFF_FAULT_MASK_SECONDARY:  REG_RDATA_O <= mask2_ff;
                OFF_INTRUSION_CLEAR:       REG_RDATA_O <= {iclr_ff, 7'h00};
                default:                   REG_RDATA_O <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_RUN_NEEDS_START: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) MONITOR_RUN_O |-> $past(cfg_ff[CFG_START_BIT]))
        else $error("monitor runs without start");
    AST_CLR_SUSPENDS: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        $past(cfg_ff[CFG_IRQ_CLR_BIT]) |-> !MONITOR_RUN_O)
        else $error("monitor runs while clear set");
    AST_IRQ_GATED: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I) !$past(cfg_ff[CFG_IRQ_EN_BIT]) |-> IRQ_N_O)
        else $error("irq asserted while disabled");
    AST_IRQ_CLEAR: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        $rose(cfg_ff[CFG_IRQ_CLR_BIT]) && $stable(flags1_ff) |-> ##1 IRQ_N_O)
        else $error("clear bit did not release irq");
    AST_IRQ_RAISE: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        cfg_ff[CFG_IRQ_EN_BIT] && !cfg_ff[CFG_IRQ_CLR_BIT]
        && |(flags1_ff & ~mask1_ff & FLAGS1_USED) |=> !IRQ_N_O)
        else $error("irq missing for unmasked flag");
    AST_READ_CLEARS: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        rd_f1 && !reinit && !MONITOR_RUN_O |=> flags1_ff == 8'h00)
        else $error("flags not cleared by read");
    AST_RST_GATED: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        $fell(RESET_OUT_N_O) |-> $past(mask2_ff[MASK2_RST_EN_BIT], 3))
        else $error("reset pulse without enable");
    AST_RST_SELFCLR: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        rst_active && !wr_cfg |=> !cfg_ff[CFG_RST_PULSE_BIT])
        else $error("reset bit not self cleared");
    AST_REINIT: assert property (@(posedge MCLK_I)
        disable iff (!RST_N_I)
        reinit |=> cfg_ff == RST_MONITOR_CONFIGURATION && mask2_ff == 8'h00)
        else $error("reinit did not restore defaults");
    COV_IRQ: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
        $fell(IRQ_N_O));
    COV_INTRUSION: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
        intr_rise);
    COV_RST: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
        rst_done);
endmodule : mci_top
`default_nettype wire

// [bench/mci_host_model.sv]
// Host model: single-byte register writes and reads over the strobe bus.
// Assumes the device takes a strobe on the rising edge that sees it high.
`timescale 1ns/1ps
`default_nettype none
module mci_host_model (
    input  wire logic       clk_i,
    output var  logic       wr_o,
    output var  logic       rd_o,
    output var  logic [7:0] addr_o,
    output var  logic [7:0] wdata_o,
    input  wire logic [7:0] rdata_i
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    // Limits are programmed before start is set by whoever calls this
    // Idle bus shows the inverse of the last address; wdata_o is inverted only after a write, a read leaves it as it was
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        rd_o = 1'b1;
        addr_o = a;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        addr_o = ~a;
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask : rd

    // Masks a faulty channel from the interrupt until the mask is written again
    task automatic quiet_channel(input logic [7:0] a, input logic [7:0] m);
        wr(a, m);
    endtask : quiet_channel
endmodule : mci_host_model
`default_nettype wire

// [bench/test_monitor_config_irq_control.sv]
// Testbench for the monitor configuration and fault-interrupt block.
// Assumes the host model drives the register strobes; pulses shortened.
`timescale 1ns/1ps
`default_nettype none
module test_monitor_config_irq_control;
    import mci_pkg::*;
    localparam int PW = 16;
    typedef struct packed {
        logic       w;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } mci_row_t;
    // Reset values, read-only and reserved bits, plain read/write
    mci_row_t rows [13] = '{
        '{1'b0, 8'h40, 8'h00, 8'h08}, '{1'b0, 8'h41, 8'h00, 8'h00},
        '{1'b0, 8'h42, 8'h00, 8'h00}, '{1'b0, 8'h43, 8'h00, 8'h00},
        '{1'b0, 8'h44, 8'h00, 8'h00}, '{1'b0, 8'h46, 8'h00, 8'h00},
        '{1'b0, 8'h45, 8'h00, 8'h00}, '{1'b1, 8'h43, 8'hA5, 8'hA5},
        '{1'b1, 8'h44, 8'h5A, 8'h5A}, '{1'b1, 8'h40, 8'h2C, 8'h08},
        '{1'b1, 8'h41, 8'hFF, 8'h00}, '{1'b1, 8'h43, 8'h00, 8'h00},
        '{1'b1, 8'h44, 8'h00, 8'h00}};
    logic MCLK_I = 1'b0;
    logic RST_N_I;
    logic REG_WR_I, REG_RD_I, intr_lvl, pin_w;
    logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O, fault_p, fault_s;
    logic INTRUSION_PIN_OE_O, INTRUSION_PIN_O, RESET_OUT_N_O;
    logic IRQ_N_O, MONITOR_RUN_O, REINIT_O;
    logic [7:0] rd_v;
    logic [15:0] ex;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;

    always #2 MCLK_I = ~MCLK_I;
    // Pin is open-drain style: the device wins while it drives low
    assign pin_w = INTRUSION_PIN_OE_O ? INTRUSION_PIN_O : intr_lvl;

    mci_top #(.PULSE_CYCLES_P(PW)) u_dut (
        .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .REG_WR_I(REG_WR_I),
        .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
        .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
        .FAULT_PRIMARY_I(fault_p), .FAULT_SECONDARY_I(fault_s),
        .INTRUSION_PIN_I(pin_w), .INTRUSION_PIN_OE_O(INTRUSION_PIN_OE_O),
        .INTRUSION_PIN_O(INTRUSION_PIN_O), .RESET_OUT_N_O(RESET_OUT_N_O),
        .IRQ_N_O(IRQ_N_O), .MONITOR_RUN_O(MONITOR_RUN_O),
        .REINIT_O(REINIT_O));
    mci_host_model u_host (
        .clk_i(MCLK_I), .wr_o(REG_WR_I), .rd_o(REG_RD_I),
        .addr_o(REG_ADDR_I), .wdata_o(REG_WDATA_I), .rdata_i(REG_RDATA_O));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task automatic tick(input int k);
        repeat (k) @(posedge MCLK_I);
        #1;
    endtask : tick

    task automatic run_rows(input int hi);
        logic [7:0] v;
        for (int i = 0; i < hi; i++) begin
            if (rows[i].w)
                u_host.wr(rows[i].a, rows[i].d);
            u_host.rd(rows[i].a, v);
            chk(v, rows[i].e);
        end
    endtask : run_rows

    // Bounded wait for a pulse, then its length in cycles
    task automatic measure(input int sel, output int len);
        int w;
        w = 0;
        len = 0;
        while (((sel ? ~RESET_OUT_N_O : INTRUSION_PIN_OE_O) !== 1'b1)
               && w < 20) begin
            tick(1);
            w++;
        end
        while (((sel ? ~RESET_OUT_N_O : INTRUSION_PIN_OE_O) === 1'b1)
               && len < 40) begin
            if (sel == 0)
                chk({7'h0, INTRUSION_PIN_O}, 8'h00);
            tick(1);
            len++;
        end
    endtask : measure

    always @(posedge MCLK_I) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        RST_N_I = 1'b0;
        fault_p = 8'h00;
        fault_s = 8'h00;
        intr_lvl = 1'b0;
        tick(4);
        RST_N_I = 1'b1;
        chk({7'h0, IRQ_N_O}, 8'h01);
        chk({7'h0, MONITOR_RUN_O}, 8'h00);
        run_rows(13);
        fault_p = 8'h01;
        tick(4);
        u_host.rd(8'h41, rd_v);
        chk(rd_v, 8'h00);
        u_host.wr(8'h40, 8'h01);
        tick(2);
        chk({7'h0, MONITOR_RUN_O}, 8'h01);
        chk({7'h0, IRQ_N_O}, 8'h01);
        u_host.rd(8'h41, rd_v);
        u_host.rd(8'h41, rd_v);
        chk(rd_v, 8'h01);
        fault_p = 8'h00;
        u_host.rd(8'h41, rd_v);
        u_host.rd(8'h41, rd_v);
        chk(rd_v, 8'h00);
        for (int i = 0; i < 16; i++) begin
            {fault_s, fault_p} = 16'(32'd1 << i);
            ex = 16'(32'd1 << i) & 16'h03DF;
            tick(3);
            {fault_s, fault_p} = 16'h0000;
            u_host.rd(i < 8 ? 8'h41 : 8'h42, rd_v);
            chk(rd_v, i < 8 ? ex[7:0] : ex[15:8]);
            u_host.rd(i < 8 ? 8'h41 : 8'h42, rd_v);
            chk(rd_v, 8'h00);
        end
        u_host.wr(8'h40, 8'h03);
        u_host.quiet_channel(8'h43, 8'h01);
        fault_p = 8'h01;
        tick(3);
        fault_p = 8'h00;
        tick(2);
        chk({7'h0, IRQ_N_O}, 8'h01);
        u_host.wr(8'h43, 8'hFE);
        tick(2);
        chk({7'h0, IRQ_N_O}, 8'h00);
        u_host.wr(8'h40, 8'h02);
        tick(2);
        chk({7'h0, IRQ_N_O}, 8'h00);
        u_host.wr(8'h40, 8'h0B);
        tick(2);
        chk({IRQ_N_O, MONITOR_RUN_O}, 8'h02);
        u_host.wr(8'h40, 8'h03);
        tick(2);
        chk({IRQ_N_O, MONITOR_RUN_O}, 8'h01);
        u_host.wr(8'h40, 8'h01);
        tick(2);
        chk({7'h0, IRQ_N_O}, 8'h01);
        u_host.rd(8'h41, rd_v);
        chk(rd_v, 8'h01);
        u_host.wr(8'h43, 8'h00);
        intr_lvl = 1'b1;
        tick(5);
        u_host.rd(8'h42, rd_v);
        chk(rd_v, 8'h10);
        u_host.rd(8'h42, rd_v);
        chk(rd_v, 8'h00);
        intr_lvl = 1'b0;
        tick(3);
        for (int k = 0; k < 2; k++) begin
            u_host.wr(k ? 8'h46 : 8'h40, k ? 8'h80 : 8'h41);
            measure(0, n);
            chk(8'(n), 8'(PW));
            u_host.rd(k ? 8'h46 : 8'h40, rd_v);
            chk(rd_v, k ? 8'h00 : 8'h01);
        end
        u_host.wr(8'h40, 8'h11);
        measure(1, n);
        chk(8'(n), 8'h00);
        u_host.wr(8'h44, 8'h80);
        u_host.wr(8'h40, 8'h11);
        measure(1, n);
        chk(8'(n), 8'(PW));
        u_host.rd(8'h40, rd_v);
        chk(rd_v, 8'h01);
        u_host.wr(8'h43, 8'hA5);
        u_host.wr(8'h40, 8'h83);
        n = 0;
        while (REINIT_O !== 1'b1 && n < 4) begin
            tick(1);
            n++;
        end
        chk({7'h0, REINIT_O}, 8'h01);
        run_rows(7);
        // Second reset in mid-run must restore the same defaults
        u_host.wr(8'h43, 8'hA5);
        RST_N_I = 1'b0;
        tick(2);
        RST_N_I = 1'b1;
        run_rows(7);
        results();
    end
endmodule : test_monitor_config_irq_control
`default_nettype wire
